// ==== rtl/lscf_device.sv ====
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Host sets nibble, then strobes low-high-low
// - Upper three bits select command, LSB ignored
// - Strobes per command: one, two or three
// - Three resets always return to command state
// - Reset halts speech, keeps all internal state
// - Load-address data nibble forwarded to memory
// - Host repeats address pairs until register full
// - One frame each 25 ms, at most 49 bits
// - Eight-bit samples at 8 kHz
// - Parameters interpolated every 3.125 ms
// - Field order energy, repeat, pitch, coefficients
// - Repeat frame keeps previous coefficients, 10 bits
// - Zero pitch reads four coefficients, zeros rest
// - Zero energy is a silent four-bit frame
// - Energy all ones ends phrase, stops talking
// - Impulses when voiced, noise when unvoiced
// - Speak starts fetch and synthesis at once
// - Talk test drives talk status on bit 1
module lscf_device
  import lscf_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYC_DEF
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  lscf_if.dev             bus,
  output logic [3:0]      mem_addr,
  output logic            mem_addr_load,
  output logic            mem_bit_req,
  input  wire logic       mem_bit,
  output logic            mem_branch,
  output logic [7:0]      sample_data,
  output logic            sample_valid,
  input  wire logic       sample_ready,
  output logic            talking
);

  logic             stb_q;
  logic             rise;
  logic             fall;
  logic [3:0]       nib;
  logic [1:0]       pend;
  lscf_cmd_t        cmd;
  lscf_cmd_t        new_cmd;
  logic             cmd_fall;
  logic             data_fall;
  logic             drv;
  logic [3:0]       rdbuf;
  logic             cmd_rd;
  logic             par_go;
  logic             bit_due;
  logic             own_q;
  logic             par_bit;
  logic [3:0]       fld;
  logic [2:0]       bcnt;
  logic [4:0]       acc;
  logic [4:0]       acc_n;
  logic             rep;
  logic             frame_ready;
  logic [4:0]       fr [NUM_PARAMS];
  logic [4:0]       start [NUM_PARAMS];
  logic [4:0]       tgt [NUM_PARAMS];
  logic [4:0]       cur [NUM_PARAMS];
  logic             last;
  logic             done;
  logic             eop;
  logic [31:0]      scnt;
  logic [4:0]       icnt;
  logic [2:0]       step;
  logic [3:0]       n;
  logic             samp_tick;
  logic             interp_tick;
  logic             frame_tick;
  logic [4:0]       pcnt;
  logic [14:0]      lfsr;
  logic             voiced;
  logic [7:0]       amp;
  logic [7:0]       next_sample;
  logic [7:0]       b1;
  logic [1:0]       fill;
  logic             full;
  logic             push;
  logic             pop;

  // Inputs are synchronous, so one stage is enough for edges
  assign rise      = bus.command_strobe && !stb_q;
  assign fall      = !bus.command_strobe && stb_q;
  assign new_cmd   = lscf_cmd_t'(nib[3:1]);
  assign cmd_fall  = fall && (pend == 2'h0);
  assign data_fall = fall && (pend != 2'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stb_q <= 1'b0;
      nib   <= 4'h0;
    end else begin
      stb_q <= bus.command_strobe;
      if (rise)
        nib <= bus.control_nibble_bus;
    end
  end

  // Nibble counter; reset code needs one strobe, so three resets
  // flush any pending data strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 2'h0;
      cmd  <= CMD_RESET;
    end else if (cmd_fall) begin
      cmd  <= new_cmd;
      pend <= lscf_strobes(new_cmd) - 2'h1;
    end else if (data_fall) begin
      pend <= pend - 2'h1;
    end
  end

  // Address nibble forwarding, load strobe follows the data strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_addr      <= 4'h0;
      mem_addr_load <= 1'b0;
    end else begin
      mem_addr_load <= bus.command_strobe && (pend != 2'h0) &&
                       (cmd == CMD_LOAD);
      if (rise && (pend != 2'h0) && (cmd == CMD_LOAD))
        mem_addr <= bus.control_nibble_bus;
    end
  end

  // Bus turnaround for output and talk test
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drv             <= 1'b0;
      bus.dev_ctl_out <= 4'h0;
    end else begin
      if (data_fall && (cmd == CMD_OUTPUT || cmd == CMD_TTEST))
        drv <= (pend == 2'h2);
      bus.dev_ctl_out <= (cmd == CMD_TTEST) ?
                         {2'b00, talking, 1'b0} : rdbuf;
    end
  end
  assign bus.dev_ctl_oe_n = !drv;

  // Memory bit port shared by read-bit and the frame parser;
  // the command wins, the parser simply retries three cycles later
  assign cmd_rd = cmd_fall && (new_cmd == CMD_READ);
  assign par_go = talking && !frame_ready && !mem_bit_req &&
                  !bit_due && !cmd_rd;
  assign par_bit = bit_due && !own_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_bit_req <= 1'b0;
      bit_due     <= 1'b0;
      own_q       <= 1'b0;
      rdbuf       <= 4'h0;
      mem_branch  <= 1'b0;
    end else begin
      mem_bit_req <= cmd_rd || par_go;
      bit_due     <= mem_bit_req;
      if (cmd_rd || par_go)
        own_q <= cmd_rd;
      if (bit_due && own_q)
        rdbuf <= {rdbuf[2:0], mem_bit};
      mem_branch <= cmd_fall && (new_cmd == CMD_BRANCH);
    end
  end

  // Reset only stops talking; parser and filter state are kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      talking <= 1'b0;
    else if (cmd_fall && new_cmd == CMD_SPEAK)
      talking <= 1'b1;
    else if ((cmd_fall && new_cmd == CMD_RESET) || eop)
      talking <= 1'b0;
  end

  // Frame parser
  assign acc_n = {acc[3:0], mem_bit};
  assign last  = par_bit && ((bcnt + 3'h1) == lscf_fld_width(fld));
  assign eop   = last && (fld == FLD_ENERGY) &&
                 (acc_n[3:0] == ENERGY_EOP);
  assign done  = last && (((fld == FLD_ENERGY) &&
                  (acc_n[3:0] == ENERGY_SILENT ||
                   acc_n[3:0] == ENERGY_EOP)) ||
                 ((fld == FLD_PITCH) && rep) ||
                 ((fld == FLD_K4) && fr[PIX_PITCH] == PITCH_UNVOICED) ||
                 (fld == FLD_LAST));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fld         <= FLD_ENERGY;
      bcnt        <= 3'h0;
      acc         <= 5'h00;
      rep         <= 1'b0;
      frame_ready <= 1'b0;
      for (int i = 0; i < NUM_PARAMS; i++)
        fr[i] <= 5'h00;
    end else begin
      if (frame_tick && frame_ready)
        frame_ready <= 1'b0;
      if (par_bit && !last) begin
        bcnt <= bcnt + 3'h1;
        acc  <= acc_n;
      end else if (last) begin
        bcnt <= 3'h0;
        acc  <= 5'h00;
        if (fld == FLD_REPEAT)
          rep <= acc_n[0];
        else if (fld == FLD_ENERGY)
          fr[PIX_ENERGY] <= acc_n;
        else if (fld == FLD_PITCH)
          fr[PIX_PITCH] <= acc_n;
        else
          fr[fld - 4'h1] <= acc_n;
        if (done) begin
          fld <= FLD_ENERGY;
          if (!eop)
            frame_ready <= 1'b1;
          if (fld == FLD_K4)
            for (int i = PIX_ZERO_FROM; i < NUM_PARAMS; i++)
              fr[i] <= 5'h00;
        end else begin
          fld <= fld + 4'h1;
        end
      end
    end
  end

  // Timebase; a full sample buffer freezes it, so nothing is lost
  assign samp_tick   = talking && !full &&
                       (scnt == 32'(SAMPLE_CYC - 1));
  assign interp_tick = samp_tick &&
                       (icnt == 5'(SAMP_PER_INTERP - 1));
  assign frame_tick  = interp_tick &&
                       (step == 3'(INTERP_PER_FRAME - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scnt <= 32'h0;
      icnt <= 5'h00;
      step <= 3'h0;
    end else if (talking) begin
      if (scnt != 32'(SAMPLE_CYC - 1))
        scnt <= scnt + 32'h1;
      else if (!full)
        scnt <= 32'h0;
      if (samp_tick)
        icnt <= interp_tick ? 5'h00 : icnt + 5'h01;
      if (interp_tick)
        step <= step + 3'h1;
    end
  end

  // Linear blend: cur = (start*(8-n) + tgt*n) / 8
  assign n = {1'b0, step} + 4'h1;

  for (genvar g = 0; g < NUM_PARAMS; g++) begin : g_interp
    logic [9:0] mix;
    assign mix = ({5'h00, start[g]} * {6'h00, 4'h8 - n}) +
                 ({5'h00, tgt[g]} * {6'h00, n});
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        start[g] <= 5'h00;
        tgt[g]   <= 5'h00;
        cur[g]   <= 5'h00;
      end else begin
        if (interp_tick)
          cur[g] <= mix[7:3];
        if (frame_tick) begin
          start[g] <= tgt[g];
          if (frame_ready)
            tgt[g] <= fr[g];
        end
      end
    end
  end

  // Excitation only; the lattice filter is outside this block
  assign voiced = (cur[PIX_PITCH] != PITCH_UNVOICED);
  assign amp    = {1'b0, cur[PIX_ENERGY][3:0], 3'b000};
  assign next_sample = voiced ? ((pcnt == 5'h00) ? amp : 8'h00) :
                       (lfsr[0] ? amp : 8'h00 - amp);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pcnt <= 5'h00;
      lfsr <= LFSR_SEED;
    end else if (samp_tick) begin
      lfsr <= {lfsr[13:0], lfsr[14] ^ lfsr[13]};
      if (!voiced || pcnt >= cur[PIX_PITCH])
        pcnt <= 5'h00;
      else
        pcnt <= pcnt + 5'h01;
    end
  end

  // Two-entry output buffer
  assign push         = samp_tick;
  assign pop          = sample_valid && sample_ready;
  assign sample_valid = (fill != 2'h0);
  assign full         = (fill == 2'h2);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fill        <= 2'h0;
      sample_data <= 8'h00;
      b1          <= 8'h00;
    end else if (push && !pop) begin
      fill <= fill + 2'h1;
      if (fill == 2'h0)
        sample_data <= next_sample;
      else
        b1 <= next_sample;
    end else if (pop && !push) begin
      fill        <= fill - 2'h1;
      sample_data <= b1;
    end else if (push && pop) begin
      if (fill == 2'h1) begin
        sample_data <= next_sample;
      end else begin
        sample_data <= b1;
        b1          <= next_sample;
      end
    end
  end

endmodule
`default_nettype wire

// ==== shared/lscf_pkg.sv ====
`default_nettype none
package lscf_pkg;

  // Timebase
  localparam int unsigned CLK_HZ           = 200_000_000;
  localparam int unsigned SAMPLE_HZ        = 8000;
  localparam int unsigned SAMPLE_CYC_DEF   = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned INTERP_US        = 3125;
  localparam int unsigned FRAME_MS         = 25;
  localparam int unsigned SAMP_PER_INTERP  =
    INTERP_US * SAMPLE_HZ / 1_000_000;
  localparam int unsigned INTERP_PER_FRAME = FRAME_MS * 1000 / INTERP_US;
  localparam int unsigned STB_PHASE_NS     = 50;
  localparam int unsigned STB_PHASE_CYC    =
    (STB_PHASE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // Frame fields in stream order
  localparam logic [3:0] FLD_ENERGY = 4'h0;
  localparam logic [3:0] FLD_REPEAT = 4'h1;
  localparam logic [3:0] FLD_PITCH  = 4'h2;
  localparam logic [3:0] FLD_K1     = 4'h3;
  localparam logic [3:0] FLD_K3     = 4'h5;
  localparam logic [3:0] FLD_K4     = 4'h6;
  localparam logic [3:0] FLD_K8     = 4'ha;
  localparam logic [3:0] FLD_LAST   = 4'hc;
  localparam logic [2:0] W_ENERGY   = 3'h4;
  localparam logic [2:0] W_REPEAT   = 3'h1;
  localparam logic [2:0] W_WIDE     = 3'h5;
  localparam logic [2:0] W_MID      = 3'h4;
  localparam logic [2:0] W_NARROW   = 3'h3;

  // Parameter slots: energy, pitch, then reflection_coeffs 1..10
  localparam int unsigned NUM_PARAMS    = 12;
  localparam int unsigned PIX_ENERGY    = 0;
  localparam int unsigned PIX_PITCH     = 1;
  localparam int unsigned PIX_ZERO_FROM = 6;

  localparam logic [3:0]  ENERGY_SILENT  = 4'h0;
  localparam logic [3:0]  ENERGY_EOP     = 4'hf;
  localparam logic [4:0]  PITCH_UNVOICED = 5'h00;
  localparam logic [3:0]  CTL_IDLE       = 4'hf;
  localparam logic [14:0] LFSR_SEED      = 15'h0001;

  typedef enum logic [2:0] {
    CMD_RESET  = 3'b000,
    CMD_LOAD   = 3'b001,
    CMD_OUTPUT = 3'b010,
    CMD_SPARE  = 3'b011,
    CMD_READ   = 3'b100,
    CMD_SPEAK  = 3'b101,
    CMD_BRANCH = 3'b110,
    CMD_TTEST  = 3'b111
  } lscf_cmd_t;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SETUP = 2'b01,
    HS_HIGH  = 2'b10,
    HS_HOLD  = 2'b11
  } lscf_hstate_t;

  function automatic logic [1:0] lscf_strobes(lscf_cmd_t c);
    unique case (c)
      CMD_LOAD:              return 2'h2;
      CMD_OUTPUT, CMD_TTEST: return 2'h3;
      default:               return 2'h1;
    endcase
  endfunction

  function automatic logic [2:0] lscf_fld_width(logic [3:0] f);
    if (f == FLD_ENERGY)
      return W_ENERGY;
    else if (f == FLD_REPEAT)
      return W_REPEAT;
    else if (f < FLD_K3)
      return W_WIDE;
    else if (f < FLD_K8)
      return W_MID;
    else
      return W_NARROW;
  endfunction

endpackage
`default_nettype wire

// ==== shared/lscf_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lscf_if;
  import lscf_pkg::*;
  logic [3:0] host_ctl_out;
  logic       host_ctl_oe_n;
  logic [3:0] dev_ctl_out;
  logic       dev_ctl_oe_n;
  logic       command_strobe;
  logic [3:0] control_nibble_bus;

  // Pulled high when nobody drives
  assign control_nibble_bus = !dev_ctl_oe_n  ? dev_ctl_out :
                              !host_ctl_oe_n ? host_ctl_out : CTL_IDLE;

  modport host (
    output host_ctl_out,
    output host_ctl_oe_n,
    output command_strobe,
    input  control_nibble_bus
  );
  modport dev (
    output dev_ctl_out,
    output dev_ctl_oe_n,
    input  command_strobe,
    input  control_nibble_bus
  );
endinterface
`default_nettype wire

// ==== rtl/lscf_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module lscf_host
  import lscf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  lscf_if.host            bus,
  input  wire logic       req_valid,
  input  wire logic [3:0] req_nibble,
  output logic            req_ready,
  output logic            rd_valid,
  output logic [3:0]      rd_data
);

  lscf_hstate_t st;
  logic [7:0]   pcnt;
  logic [1:0]   pend;
  lscf_cmd_t    cmd;
  logic [3:0]   nib;
  logic         rel;
  logic         sample_rd;
  logic         phase_end;
  lscf_cmd_t    new_cmd;

  assign new_cmd   = lscf_cmd_t'(req_nibble[3:1]);
  assign req_ready = (st == HS_IDLE);
  assign phase_end = (pcnt == 8'(STB_PHASE_CYC - 1));

  // Strobe sequencer: setup low, high, hold low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st   <= HS_IDLE;
      pcnt <= 8'h00;
    end else if (st == HS_IDLE) begin
      pcnt <= 8'h00;
      if (req_valid)
        st <= HS_SETUP;
    end else if (!phase_end) begin
      pcnt <= pcnt + 8'h01;
    end else begin
      pcnt <= 8'h00;
      unique case (st)
        HS_SETUP: st <= HS_HIGH;
        HS_HIGH:  st <= HS_HOLD;
        HS_HOLD:  st <= HS_IDLE;
        default:  st <= HS_IDLE;
      endcase
    end
  end

  assign bus.command_strobe = (st == HS_HIGH);

  // Mirror of the device's nibble count, so we know when it talks back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend      <= 2'h0;
      cmd       <= CMD_RESET;
      nib       <= 4'h0;
      rel       <= 1'b0;
      sample_rd <= 1'b0;
    end else if (req_valid && req_ready) begin
      nib <= req_nibble;
      if (pend == 2'h0) begin
        cmd       <= new_cmd;
        pend      <= lscf_strobes(new_cmd) - 2'h1;
        rel       <= 1'b0;
        sample_rd <= 1'b0;
      end else begin
        pend      <= pend - 2'h1;
        rel       <= (cmd == CMD_OUTPUT) || (cmd == CMD_TTEST);
        sample_rd <= (pend == 2'h2);
      end
    end
  end

  assign bus.host_ctl_out  = nib;
  assign bus.host_ctl_oe_n = rel;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid <= 1'b0;
      rd_data  <= 4'h0;
    end else begin
      rd_valid <= 1'b0;
      if (st == HS_HOLD && phase_end && sample_rd) begin
        rd_valid <= 1'b1;
        rd_data  <= bus.control_nibble_bus;
      end
    end
  end

endmodule
`default_nettype wire

// ==== tb/lscf_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module lscf_asserts
  import lscf_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [3:0] host_ctl_out,
  input wire logic       host_ctl_oe_n,
  input wire logic [3:0] dev_ctl_out,
  input wire logic       dev_ctl_oe_n,
  input wire logic       command_strobe,
  input wire logic [3:0] control_nibble_bus
);
  logic [4:0] low_cnt;

  // Setup phase is too long for a repetition, so count it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      low_cnt <= 5'h00;
    end else if (command_strobe) begin
      low_cnt <= 5'h00;
    end else if (low_cnt != 5'h1f) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_strobe_setup: assert property (
    $rose(command_strobe) |-> low_cnt >= 5'h0a)
    else $error("strobe rose without full setup phase");
  a_strobe_high_len: assert property (
    $rose(command_strobe) |->
      command_strobe[*8] ##2 command_strobe ##1 !command_strobe)
    else $error("strobe high phase has wrong length");
  a_strobe_hold: assert property (
    $fell(command_strobe) |-> !command_strobe[*8])
    else $error("strobe hold phase too short");
  a_bus_stable_high: assert property (
    command_strobe && $past(command_strobe) && dev_ctl_oe_n
      |-> $stable(control_nibble_bus))
    else $error("bus changed while strobe high");
  a_no_contention: assert property (
    !(!dev_ctl_oe_n && !host_ctl_oe_n))
    else $error("both ends drive the bus");
  a_drive_start: assert property (
    $fell(dev_ctl_oe_n) |-> !command_strobe && !$past(command_strobe)
      && ($past(command_strobe, 3) || $past(command_strobe, 4)))
    else $error("device drive not tied to strobe fall");
  a_drive_release: assert property (
    $rose(dev_ctl_oe_n) |-> !command_strobe && !$past(command_strobe)
      && ($past(command_strobe, 3) || $past(command_strobe, 4)))
    else $error("device release not tied to strobe fall");
  a_drive_held: assert property (
    !dev_ctl_oe_n && command_strobe |-> ##1 !dev_ctl_oe_n)
    else $error("device released bus during strobe");
  a_idle_level: assert property (
    dev_ctl_oe_n && host_ctl_oe_n |-> control_nibble_bus == CTL_IDLE)
    else $error("undriven bus not at idle level");

  c_strobe: cover property ($rose(command_strobe));
  c_dev_drive: cover property ($fell(dev_ctl_oe_n));
  c_dev_release: cover property ($rose(dev_ctl_oe_n));
endmodule
`default_nettype wire

// ==== tb/test_lscf_speech_command_frame_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_lscf_speech_command_frame_unit;
  import lscf_pkg::*;
  logic       clk           = 1'b0;
  logic       rstn          = 1'b0;
  logic       req_valid     = 1'b0;
  logic [3:0] req_nibble    = 4'h0;
  logic       mem_bit       = 1'b0;
  logic       sample_ready  = 1'b1;
  logic       req_ready;
  logic       rd_valid;
  logic [3:0] rd_data;
  logic [3:0] mem_addr;
  logic       mem_addr_load;
  logic       mem_bit_req;
  logic       mem_branch;
  logic [7:0] sample_data;
  logic       sample_valid;
  logic       talking;
  logic       load_q        = 1'b0;
  logic       stream [0:127];
  int         wp, nreq, n_load, n_samp, n_branch;
  int         miscompares, num_checks;
  logic [3:0] v;

  always #2.5 clk = ~clk;

  lscf_if u_lscf_if ();
  lscf_host u_lscf_host (.clk(clk), .rstn(rstn), .bus(u_lscf_if),
    .req_valid(req_valid), .req_nibble(req_nibble),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  lscf_device #(.SAMPLE_CYC(20)) u_lscf_device (.clk(clk), .rstn(rstn),
    .bus(u_lscf_if), .mem_addr(mem_addr), .mem_addr_load(mem_addr_load),
    .mem_bit_req(mem_bit_req), .mem_bit(mem_bit),
    .mem_branch(mem_branch), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .talking(talking));
  lscf_asserts u_lscf_asserts (.clk(clk), .rstn(rstn),
    .host_ctl_out(u_lscf_if.host_ctl_out),
    .host_ctl_oe_n(u_lscf_if.host_ctl_oe_n),
    .dev_ctl_out(u_lscf_if.dev_ctl_out),
    .dev_ctl_oe_n(u_lscf_if.dev_ctl_oe_n),
    .command_strobe(u_lscf_if.command_strobe),
    .control_nibble_bus(u_lscf_if.control_nibble_bus));

  // Serial memory: next bit valid the cycle after a request
  always @(posedge clk) begin
    if (mem_bit_req === 1'b1) begin
      mem_bit <= stream[nreq];
      nreq <= nreq + 1;
    end
    load_q <= mem_addr_load;
    if (mem_addr_load === 1'b1 && load_q === 1'b0) n_load <= n_load + 1;
    if (mem_branch === 1'b1) n_branch <= n_branch + 1;
    if (sample_valid === 1'b1 && sample_ready) n_samp <= n_samp + 1;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic send(input logic [3:0] n);
    int i;
    @(posedge clk);
    req_nibble <= n;
    req_valid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (req_ready === 1'b1) break;
    end
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task automatic rd3(input logic [3:0] c, output logic [3:0] r);
    int i;
    send(c);
    send(4'h0);
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) break;
    end
    r = rd_data;
    send(4'h0);
  endtask

  // Fields go out most significant bit first
  task automatic put(input logic [4:0] val, input int w);
    int i;
    for (i = w - 1; i >= 0; i--) begin
      stream[wp] = val[i];
      wp++;
    end
  endtask

  task automatic t_load();
    int i;
    for (i = 0; i < 5; i++) begin
      send({3'b001, i[0]});
      send(4'h5 + 4'(i));
      wait_cyc(25);
      check("mem_addr", 16'(mem_addr), 16'(4'h5 + 4'(i)));
    end
    check("load count", 16'(n_load), 16'h0005);
  endtask

  task automatic t_resync();
    send(4'h2);
    send(4'h0);
    send(4'h1);
    send(4'h0);
    send(4'h6);
    rd3(4'hf, v);
    check("resync status", 16'(v), 16'h0000);
    check("resync addr", 16'(mem_addr), 16'h0000);
  endtask

  task automatic t_readout();
    repeat (2) send(4'h8);
    repeat (2) send(4'h9);
    rd3(4'h4, v);
    check("output nibble", 16'(v), 16'h000b);
    check("bits read", 16'(nreq), 16'h0004);
  endtask

  task automatic t_speech();
    int s0, i;
    send(4'ha);
    wait_cyc(600);
    rd3(4'he, v);
    check("talk status", 16'(v), 16'h0002);
    s0 = n_samp;
    wait_cyc(400);
    check("rate", 16'(n_samp - s0 >= 19 && n_samp - s0 <= 21), 16'h0001);
    sample_ready <= 1'b0;
    wait_cyc(100);
    check("held valid", 16'(sample_valid), 16'h0001);
    // No frame has become the target yet, so amplitude is still zero
    check("early sample", 16'(sample_data), 16'h0000);
    s0 = n_samp;
    sample_ready <= 1'b1;
    wait_cyc(2);
    sample_ready <= 1'b0;
    @(negedge clk);
    check("buffered words", 16'(n_samp - s0), 16'h0002);
    @(posedge clk);
    sample_ready <= 1'b1;
    send(4'h1);
    wait_cyc(40);
    check("halted", 16'(talking), 16'h0000);
    s0 = n_samp;
    wait_cyc(100);
    check("no samples", 16'(n_samp - s0), 16'h0000);
    send(4'hb);
    wait_cyc(40);
    check("resumed", 16'(talking), 16'h0001);
    for (i = 0; i < 40000; i++) begin
      @(negedge clk);
      if (talking === 1'b0) break;
    end
    check("phrase end", 16'(talking), 16'h0000);
    check("bits used", 16'(nreq), 16'h0063);
    rd3(4'he, v);
    check("idle status", 16'(v), 16'h0000);
    send(4'hd);
    wait_cyc(40);
    check("branch", 16'(n_branch), 16'h0001);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 128; i++) stream[i] = i[0];
    put(5'h0b, 4);
    // Voiced, repeat, silent, unvoiced, end of phrase
    put(5'h08, 4); put(5'h00, 1); put(5'h10, 5); put(5'h14, 5);
    put(5'h0a, 5);
    repeat (5) put(5'h04, 4);
    repeat (3) put(5'h01, 3);
    put(5'h08, 4); put(5'h01, 1); put(5'h10, 5);
    put(5'h00, 4);
    put(5'h08, 4); put(5'h00, 1); put(5'h00, 5); put(5'h18, 5);
    put(5'h02, 5); put(5'h07, 4); put(5'h05, 4);
    put(5'h0f, 4);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_load();
    t_resync();
    t_readout();
    t_speech();
    summarize();
  end

  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
